//--- rtl/ftr_regs.sv
// Threshold, critical limit, hysteresis, test-enable and offset registers with
// the per-channel fan start and full-duty fail-safe decisions they steer.
// Assumes readings arrive with a one-cycle conversion strobe per channel and
// that the lock bit is held in a configuration register outside this block.
//
// Operation
// - Above start threshold run minimum duty, ramp up
// - Lock set: writes to these registers ignored
// - Any channel over limit forces full duty
// - Limit code 0x80 disables the fail-safe
// - Fail-safe holds until below limit minus hysteresis
// - Overtemp pin low when quarter degree over
// - Four-bit hysteresis fields at documented positions
// - Below start, minimum duty until start minus hysteresis
// - Hysteresis serves fan and dynamic threshold loops
// - Test bit enters and leaves tree test mode
// - Remote-one offset, half degrees, added to reading
// - Local offset, half degrees, added to reading
// - Minimum duty linear: zero off, all ones full
//
// The strobed register port was chosen for this implementation.
`default_nettype none

module ftr_regs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Configuration from outside the bank
  input  wire logic       global_lock,
  input  wire logic       overtemp_pin_is_output,
  // Conversion results, quarter degrees, two's complement
  input  wire logic [2:0] conv_valid,
  input  wire logic [9:0] remote1_temp_raw,
  input  wire logic [9:0] local_temp_raw,
  input  wire logic [9:0] remote2_temp_raw,
  // Fan loop settings
  input  wire logic [7:0] remote1_minimum_fan_duty,
  input  wire logic [7:0] local_minimum_fan_duty,
  input  wire logic [7:0] remote2_minimum_fan_duty,
  input  wire logic [2:0] remote1_temp_control_span,
  input  wire logic [2:0] local_temp_control_span,
  input  wire logic [2:0] remote2_temp_control_span,
  // Fan control results
  output logic      [7:0] remote1_fan_duty,
  output logic      [7:0] local_fan_duty,
  output logic      [7:0] remote2_fan_duty,
  output logic      [2:0] fan_control_active,
  output logic            fail_safe_full_duty,
  // Hysteresis for the dynamic threshold loop
  output logic      [3:0] remote1_hyst,
  output logic      [3:0] local_hyst,
  output logic      [3:0] remote2_hyst,
  // Overtemperature pin, open drain
  output logic            overtemp_signal_o,
  output logic            overtemp_signal_oe_n,
  // Test mode
  output logic            tree_test_enable
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0]  start;
    logic [2:0][7:0]  limit;
    logic [7:0]       hyst_a;
    logic [7:0]       hyst_b;
    logic             test_en;
    logic [7:0]       off_r1;
    logic [7:0]       off_loc;
    logic [2:0][10:0] temp;
    logic [2:0]       active;
    logic [2:0]       fs;
    logic             fs_any;
    logic [2:0][7:0]  duty;
    logic             ot_oe_n;
    logic [7:0]       rdata;
  } ftr_state_s;

  ftr_state_s st;
  ftr_state_s next_st;

  logic [2:0][9:0] raw;
  logic [2:0][7:0] min_duty;
  logic [2:0][2:0] span;
  logic [2:0][7:0] offset;
  logic [2:0][3:0] hyst;
  logic [2:0][10:0] corr;
  logic [2:0][7:0] ramp_duty;
  logic [2:0]      hot;
  logic [2:0]      cold;
  logic [2:0]      crit_on;
  logic [2:0]      crit_off;
  logic [2:0]      ot_hit;
  logic            wr_ok;

  assign raw      = {remote2_temp_raw, local_temp_raw, remote1_temp_raw};
  assign min_duty = {remote2_minimum_fan_duty, local_minimum_fan_duty,
                     remote1_minimum_fan_duty};
  assign span     = {remote2_temp_control_span, local_temp_control_span,
                     remote1_temp_control_span};
  assign offset   = {ftr_pkg::RST_ZERO, st.off_loc, st.off_r1};
  assign hyst[0]  = st.hyst_a[ftr_pkg::HYST_HI_LSB +: 4];
  assign hyst[1]  = st.hyst_a[ftr_pkg::HYST_LO_LSB +: 4];
  assign hyst[2]  = st.hyst_b[ftr_pkg::HYST_HI_LSB +: 4];
  assign wr_ok    = reg_wr && !global_lock;

  // ---------------------------------------------------------------------------
  // Per-channel comparisons
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < ftr_pkg::NUM_CH; i++) begin : g_ch
    logic signed [10:0] raw_q;
    logic signed [10:0] off_q;
    logic signed [9:0]  deg;
    logic signed [9:0]  start_d;
    logic signed [9:0]  lim_d;
    logic signed [9:0]  hyst_d;
    logic signed [10:0] lim_q;
    logic        [9:0]  excess;
    logic        [17:0] ramp;
    logic               lim_off;

    // Offset in half degrees lands as two quarter-degree steps
    assign raw_q   = {raw[i][9], raw[i]};
    assign off_q   = {offset[i][7], offset[i][7], offset[i], 1'b0};
    assign corr[i] = 11'(raw_q + off_q);
    // Whole degrees, sign-extended for margin on subtraction
    assign deg     = {st.temp[i][10], st.temp[i][10:2]};
    assign start_d = {st.start[i][7], st.start[i][7], st.start[i]};
    assign lim_d   = {st.limit[i][7], st.limit[i][7], st.limit[i]};
    assign hyst_d  = {6'h00, hyst[i]};
    assign lim_q   = {st.limit[i][7], st.limit[i], 2'b00};
    assign lim_off = st.limit[i] == ftr_pkg::LIMIT_DISABLE;

    assign hot[i]      = deg > start_d;
    assign cold[i]     = deg <= 10'(start_d - hyst_d);
    assign crit_on[i]  = !lim_off && (deg > lim_d);
    assign crit_off[i] = lim_off || (deg < 10'(lim_d - hyst_d));
    assign ot_hit[i]   = !lim_off && ($signed(st.temp[i]) > lim_q);

    // Duty climbs from the minimum with the excess over the start point
    assign excess = 10'(deg - start_d);
    assign ramp   = 18'({8'h00, excess} << span[i]) + 18'(min_duty[i]);
    assign ramp_duty[i] = (ramp > 18'(ftr_pkg::DUTY_FULL)) ? ftr_pkg::DUTY_FULL
                                                           : ramp[7:0];
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Register writes, refused entirely while locked
    if (wr_ok) begin
      case (reg_addr)
        ftr_pkg::ADDR_START_R1:  next_st.start[0] = reg_wdata;
        ftr_pkg::ADDR_START_LOC: next_st.start[1] = reg_wdata;
        ftr_pkg::ADDR_START_R2:  next_st.start[2] = reg_wdata;
        ftr_pkg::ADDR_LIMIT_R1:  next_st.limit[0] = reg_wdata;
        ftr_pkg::ADDR_LIMIT_LOC: next_st.limit[1] = reg_wdata;
        ftr_pkg::ADDR_LIMIT_R2:  next_st.limit[2] = reg_wdata;
        ftr_pkg::ADDR_HYST_A:    next_st.hyst_a   = reg_wdata;
        ftr_pkg::ADDR_HYST_B:    next_st.hyst_b   = reg_wdata;
        ftr_pkg::ADDR_TEST:      next_st.test_en  = reg_wdata[ftr_pkg::TEST_BIT];
        ftr_pkg::ADDR_OFF_R1:    next_st.off_r1   = reg_wdata;
        ftr_pkg::ADDR_OFF_LOC:   next_st.off_loc  = reg_wdata;
        default: ;
      endcase
    end
    // Read data stand for exactly one cycle
    next_st.rdata = ftr_pkg::RST_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ftr_pkg::ADDR_START_R1:  next_st.rdata = st.start[0];
        ftr_pkg::ADDR_START_LOC: next_st.rdata = st.start[1];
        ftr_pkg::ADDR_START_R2:  next_st.rdata = st.start[2];
        ftr_pkg::ADDR_LIMIT_R1:  next_st.rdata = st.limit[0];
        ftr_pkg::ADDR_LIMIT_LOC: next_st.rdata = st.limit[1];
        ftr_pkg::ADDR_LIMIT_R2:  next_st.rdata = st.limit[2];
        ftr_pkg::ADDR_HYST_A:    next_st.rdata = st.hyst_a;
        ftr_pkg::ADDR_HYST_B:    next_st.rdata = st.hyst_b;
        ftr_pkg::ADDR_TEST:      next_st.rdata = {7'h00, st.test_en};
        ftr_pkg::ADDR_OFF_R1:    next_st.rdata = st.off_r1;
        ftr_pkg::ADDR_OFF_LOC:   next_st.rdata = st.off_loc;
        default:                 next_st.rdata = ftr_pkg::RST_ZERO;
      endcase
    end
    // Fan decisions per channel
    for (int i = 0; i < ftr_pkg::NUM_CH; i++) begin
      if (conv_valid[i]) begin
        next_st.temp[i] = corr[i];
      end
      if (hot[i]) begin
        next_st.active[i] = 1'b1;
      end else if (cold[i]) begin
        next_st.active[i] = 1'b0;
      end
      if (crit_on[i]) begin
        next_st.fs[i] = 1'b1;
      end else if (crit_off[i]) begin
        next_st.fs[i] = 1'b0;
      end
      if (|st.fs) begin
        next_st.duty[i] = ftr_pkg::DUTY_FULL;
      end else if (hot[i]) begin
        next_st.duty[i] = ramp_duty[i];
      end else if (st.active[i]) begin
        next_st.duty[i] = min_duty[i];
      end else begin
        next_st.duty[i] = ftr_pkg::DUTY_OFF;
      end
    end
    next_st.fs_any  = |next_st.fs;
    next_st.ot_oe_n = !(overtemp_pin_is_output && (|ot_hit));
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st.start   <= {3{ftr_pkg::RST_START}};
      st.limit   <= {3{ftr_pkg::RST_LIMIT}};
      st.hyst_a  <= ftr_pkg::RST_HYST_A;
      st.hyst_b  <= ftr_pkg::RST_HYST_B;
      st.test_en <= 1'b0;
      st.off_r1  <= ftr_pkg::RST_ZERO;
      st.off_loc <= ftr_pkg::RST_ZERO;
      st.temp    <= '0;
      st.active  <= 3'b000;
      st.fs      <= 3'b000;
      st.fs_any  <= 1'b0;
      st.duty    <= '0;
      st.ot_oe_n <= 1'b1;
      st.rdata   <= ftr_pkg::RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata            = st.rdata;
  assign remote1_fan_duty     = st.duty[0];
  assign local_fan_duty       = st.duty[1];
  assign remote2_fan_duty     = st.duty[2];
  assign fan_control_active   = st.active;
  assign fail_safe_full_duty  = st.fs_any;
  assign remote1_hyst         = hyst[0];
  assign local_hyst           = hyst[1];
  assign remote2_hyst         = hyst[2];
  assign overtemp_signal_o    = 1'b0;
  assign overtemp_signal_oe_n = st.ot_oe_n;
  assign tree_test_enable     = st.test_en;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_write(logic [7:0] a, logic lk);
    reg_wr && reg_addr == a && global_lock == lk;
  endsequence

  chk_lock_write_ignored: assert property (
    seq_write(ftr_pkg::ADDR_LIMIT_LOC, 1'b1) |=> $stable(st.limit[1]))
    else $error("locked write changed a limit");

  chk_start_write_taken: assert property (
    seq_write(ftr_pkg::ADDR_START_R2, 1'b0) |=> st.start[2] == $past(reg_wdata))
    else $error("unlocked start write lost");

  chk_failsafe_full_duty: assert property (
    (|st.fs) |=> remote1_fan_duty == 8'hFF && local_fan_duty == 8'hFF
                 && remote2_fan_duty == 8'hFF)
    else $error("fail-safe did not force full duty");

  chk_limit_disabled: assert property (
    st.limit[2] == ftr_pkg::LIMIT_DISABLE ##1 st.limit[2] == ftr_pkg::LIMIT_DISABLE
      |-> !st.fs[2])
    else $error("disabled limit still engaged fail-safe");

  chk_failsafe_hold: assert property (
    st.fs[1] && !crit_off[1] |=> st.fs[1])
    else $error("fail-safe released above limit minus hysteresis");

  chk_overtemp_pin: assert property (
    overtemp_pin_is_output && (|ot_hit) |=> !overtemp_signal_oe_n)
    else $error("overtemp pin not driven");

  chk_hyst_fields: assert property (
    seq_write(ftr_pkg::ADDR_HYST_A, 1'b0) |=> remote1_hyst == $past(reg_wdata[7:4])
      && local_hyst == $past(reg_wdata[3:0]))
    else $error("hysteresis fields misplaced");

  chk_min_duty_hold: assert property (
    st.active[1] && !hot[1] && !(|st.fs) |=> local_fan_duty == $past(min_duty[1]))
    else $error("minimum duty not held in hysteresis band");

  chk_fan_off: assert property (
    !st.active[1] && !hot[1] && !(|st.fs) |=> local_fan_duty == 8'h00)
    else $error("idle fan not off");

  chk_test_bit: assert property (
    seq_write(ftr_pkg::ADDR_TEST, 1'b0) |=> tree_test_enable == $past(reg_wdata[0]))
    else $error("test bit not taken");

  chk_offset_add: assert property (
    conv_valid[0] |=> st.temp[0] == 11'($past({remote1_temp_raw[9], remote1_temp_raw})
      + $past({st.off_r1[7], st.off_r1[7], st.off_r1, 1'b0})))
    else $error("remote-one offset not applied");

  chk_local_offset: assert property (
    conv_valid[1] |=> st.temp[1] == 11'($past({local_temp_raw[9], local_temp_raw})
      + $past({st.off_loc[7], st.off_loc[7], st.off_loc, 1'b0})))
    else $error("local offset not applied");

  chk_start_engage: assert property (
    hot[0] |=> fan_control_active[0])
    else $error("channel above start not in control");

  chk_lock_test_bit: assert property (
    seq_write(ftr_pkg::ADDR_TEST, 1'b1) |=> $stable(tree_test_enable))
    else $error("locked write changed the test bit");

  chk_failsafe_engage: assert property (
    crit_on[2] |=> fail_safe_full_duty)
    else $error("critical channel did not engage fail-safe");

  chk_overtemp_release: assert property (
    !overtemp_pin_is_output |=> overtemp_signal_oe_n)
    else $error("overtemp pin driven while an input");

  chk_remote2_hyst: assert property (
    seq_write(ftr_pkg::ADDR_HYST_B, 1'b0) |=> remote2_hyst == $past(reg_wdata[7:4]))
    else $error("remote-two hysteresis field misplaced");

  chk_band_release: assert property (
    st.active[1] && cold[1] && !hot[1] |=> !fan_control_active[1])
    else $error("fan stayed in control below the release point");

endmodule

`default_nettype wire

//--- rtl/ftr_pkg.sv
// Constants for the fan threshold, limit, hysteresis and offset register bank.
// Assumes 8-bit register addresses and 10-bit quarter-degree readings.
`default_nettype none

package ftr_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int NUM_CH   = 3;
  localparam int RAW_W    = 10;
  localparam int TEMP_W   = 11;
  localparam int DEG_W    = 9;
  localparam int CMP_W    = 10;
  localparam int RAMP_W   = 18;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_START_R1  = 8'h67;
  localparam logic [7:0] ADDR_START_LOC = 8'h68;
  localparam logic [7:0] ADDR_START_R2  = 8'h69;
  localparam logic [7:0] ADDR_LIMIT_R1  = 8'h6A;
  localparam logic [7:0] ADDR_LIMIT_LOC = 8'h6B;
  localparam logic [7:0] ADDR_LIMIT_R2  = 8'h6C;
  localparam logic [7:0] ADDR_HYST_A    = 8'h6D;
  localparam logic [7:0] ADDR_HYST_B    = 8'h6E;
  localparam logic [7:0] ADDR_TEST      = 8'h6F;
  localparam logic [7:0] ADDR_OFF_R1    = 8'h70;
  localparam logic [7:0] ADDR_OFF_LOC   = 8'h71;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_START      = 8'h5A;
  localparam logic [7:0] RST_LIMIT      = 8'h64;
  localparam logic [7:0] RST_HYST_A     = 8'h44;
  localparam logic [7:0] RST_HYST_B     = 8'h40;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] LIMIT_DISABLE  = 8'h80;
  localparam logic [7:0] DUTY_FULL      = 8'hFF;
  localparam logic [7:0] DUTY_OFF       = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int HYST_HI_LSB = 4;
  localparam int HYST_LO_LSB = 0;
  localparam int TEST_BIT    = 0;

endpackage

`default_nettype wire

//--- verif/ftr_host.sv
// Host model that reaches the register bank over its strobe port.
// Assumes the bank answers a read in the cycle after the strobe.
`default_nettype none

module ftr_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= (a == 8'h6F) ? (d & 8'h01) : d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

`default_nettype wire

//--- verif/fan_threshold_hysteresis_regs_test.sv
// Self-checking bench for the threshold, limit and offset register bank.
// Assumes the host model drives the register port.
`default_nettype none

module fan_threshold_hysteresis_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk     = 1'b0;
  logic       srst    = 1'b1;
  logic       glock   = 1'b0;
  logic       pin_out = 1'b0;
  logic [2:0] cv      = 3'h0;
  logic [9:0] r1_raw  = 10'h000;
  logic [9:0] lo_raw  = 10'h000;
  logic [9:0] r2_raw  = 10'h000;
  logic [2:0] lo_span = 3'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r1_duty, lo_duty, r2_duty, p;
  logic       reg_wr, reg_rd, fs, ot_o, ot_oe_n, tte;
  logic [2:0] act;
  logic [3:0] r1_h, lo_h, r2_h;
  int         n_fail    = 0;
  int         cmp_count = 0;
  logic [7:0] ra [11] = '{8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E,
                          8'h6F, 8'h70, 8'h71};
  logic [7:0] rv [11] = '{8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40,
                          8'h00, 8'h00, 8'h00};
  int         fd [6]  = '{101, 96, 95, 101, 92, 91};
  logic       fe [6]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #2.5 clk = ~clk;

  ftr_host ftr_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ftr_regs ftr_regs_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_lock(glock), .overtemp_pin_is_output(pin_out), .conv_valid(cv),
    .remote1_temp_raw(r1_raw), .local_temp_raw(lo_raw), .remote2_temp_raw(r2_raw),
    .remote1_minimum_fan_duty(8'h20), .local_minimum_fan_duty(8'h40),
    .remote2_minimum_fan_duty(8'h30), .remote1_temp_control_span(3'h0),
    .local_temp_control_span(lo_span), .remote2_temp_control_span(3'h0),
    .remote1_fan_duty(r1_duty), .local_fan_duty(lo_duty), .remote2_fan_duty(r2_duty),
    .fan_control_active(act), .fail_safe_full_duty(fs), .remote1_hyst(r1_h),
    .local_hyst(lo_h), .remote2_hyst(r2_h), .overtemp_signal_o(ot_o),
    .overtemp_signal_oe_n(ot_oe_n), .tree_test_enable(tte));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    ftr_host_inst.rd(a, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask

  task automatic rst;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask

  // One conversion on a channel, then wait until forced duties have landed
  task automatic conv(input int ch, input int q);
    @(posedge clk);
    case (ch)
      0: r1_raw <= q[9:0];
      1: lo_raw <= q[9:0];
      default: r2_raw <= q[9:0];
    endcase
    cv <= 3'(1 << ch);
    @(posedge clk);
    cv <= 3'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++) rdchk(ra[i], rv[i]);
    rdchk(8'h72, 8'h00);
    chk("r1 hyst", 8'h04, {4'h0, r1_h});
    chk("lo hyst", 8'h04, {4'h0, lo_h});
    chk("r2 hyst", 8'h04, {4'h0, r2_h});
    ftr_host_inst.wr(8'h66, 8'h5A);
    rdchk(8'h66, 8'h00);
    for (int i = 0; i < 11; i++) begin
      p = 8'hC5 - 8'(i);
      ftr_host_inst.wr(ra[i], p);
      rdchk(ra[i], (i == 8) ? (p & 8'h01) : p);
    end
    @(posedge clk);
    glock <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      p = 8'hC5 - 8'(i);
      ftr_host_inst.wr(ra[i], p ^ 8'h11);
      rdchk(ra[i], (i == 8) ? (p & 8'h01) : p);
    end
    @(posedge clk);
    glock <= 1'b0;
    rst;
    ftr_host_inst.wr(8'h6D, 8'h9C);
    ftr_host_inst.wr(8'h6E, 8'h75);
    chk("r1 hyst", 8'h09, {4'h0, r1_h});
    chk("lo hyst", 8'h0C, {4'h0, lo_h});
    chk("r2 hyst", 8'h07, {4'h0, r2_h});
    rst;
    ftr_host_inst.wr(8'h6F, 8'h01);
    chk("test en", 8'h01, {7'h0, tte});
    ftr_host_inst.wr(8'h6F, 8'h00);
    chk("test en", 8'h00, {7'h0, tte});
    conv(1, 380);
    chk("active", 8'h02, {5'h0, act});
    chk("lo duty", 8'h45, lo_duty);
    @(posedge clk);
    lo_span <= 3'h7;
    conv(1, 380);
    chk("lo duty", 8'hFF, lo_duty);
    @(posedge clk);
    lo_span <= 3'h0;
    conv(1, 352);
    chk("lo duty", 8'h40, lo_duty);
    chk("active", 8'h02, {5'h0, act});
    conv(1, 344);
    chk("active", 8'h00, {5'h0, act});
    for (int k = 0; k < 6; k++) begin
      if (k == 3) ftr_host_inst.wr(8'h6E, 8'h80);
      conv(2, fd[k] * 4);
      chk("fail safe", {7'h0, fe[k]}, {7'h0, fs});
      if (fe[k]) chk("r1 duty", 8'hFF, r1_duty);
      chk("r2 duty", fe[k] ? 8'hFF : 8'h30 + 8'(fd[k]) - ftr_pkg::RST_START, r2_duty);
    end
    ftr_host_inst.wr(8'h6C, 8'h80);
    conv(2, 480);
    chk("fail safe", 8'h00, {7'h0, fs});
    @(posedge clk);
    pin_out <= 1'b1;
    conv(1, 400);
    chk("overtemp oe", 8'h01, {7'h0, ot_oe_n});
    conv(1, 401);
    chk("overtemp oe", 8'h00, {7'h0, ot_oe_n});
    chk("overtemp o", 8'h00, {7'h0, ot_o});
    @(posedge clk);
    pin_out <= 1'b0;
    conv(1, 401);
    chk("overtemp oe", 8'h01, {7'h0, ot_oe_n});
    conv(1, 320);
    ftr_host_inst.wr(8'h70, 8'hF6);
    conv(0, 372);
    chk("r1 active", 8'h00, {7'h0, act[0]});
    ftr_host_inst.wr(8'h70, 8'h0C);
    conv(0, 344);
    chk("r1 active", 8'h01, {7'h0, act[0]});
    ftr_host_inst.wr(8'h71, 8'hF6);
    conv(1, 372);
    chk("lo active", 8'h00, {7'h0, act[1]});
    ftr_host_inst.wr(8'h71, 8'h0A);
    conv(1, 348);
    chk("lo active", 8'h01, {7'h0, act[1]});
    stop_test;
  end
endmodule

`default_nettype wire
